// ===== design/sada_acq.sv
// module: acquisition controller with apb registers, pacing, triggers, scan fifo
// What this block does
// - four simultaneous analog channels, hardware 1..4, selected by indices 0..3
// - list order does not matter; host never repeats an index
// - index 4 samples all eight digital lines like an analog channel
// - analog results are always 24 bits wide
// - each entry or single request carries gain 1, 8, 16 or 32
// - internal sample clock paces; all list channels sampled per pulse
// - software trigger: conversions start on the start write
// - external trigger: start on programmed rising or falling edge
// - single-value request returns one result, no clock, trigger or buffer
// - continuous mode uses chosen trigger and buffer until stopped or ended
// - orderly stop while running finishes scan, halts, delivers data, ignores triggers; while armed it is ignored
// - abrupt stop halts at once, discards data, ignores triggers
// - up to five inputs share one 8k-sample fifo
// - one sample per enabled channel makes a scan; host sets scan count
// - wrap mode restarts buffer, newest scans overwrite oldest, runs forever
// - no-wrap mode ends itself after the programmed scan count
// - offset binary; over range all ones, under range all zeros
// - data reaches host buffers gap-free until buffers run out or stop
// - sample pulse during busy conversion flags overrun; host clears it
// - digital sample bit reads one for closed switch, zero for open
`default_nettype none
module sada_acq #(
   parameter int fifo_depth = sada_pkg::fifo_depth,
   parameter int conv_cycles = 64
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // converter raw data and range flags
   input wire logic [4*24-1:0] raw_in,
   input wire logic [3:0] over_in,
   input wire logic [3:0] under_in,
   // gain applied to each lane's front end
   output logic [7:0] gain_out,
   // pins
   input wire logic ext_trig_in,
   input wire logic [7:0] dig_in
);
   initial if (fifo_depth < 8 || (fifo_depth & (fifo_depth - 1)) != 0) $error("fifo_depth must be a power of two");
   initial if (conv_cycles < 1 || conv_cycles > 65536) $error("conv_cycles must fit the 16-bit converter count");
   localparam int aw = $clog2(fifo_depth);

   typedef struct packed {
      sada_pkg::sada_state_type st;
      logic [31:0] ctrl;
      logic [31:0] clkdiv;
      logic [31:0] scans;
      logic [24:0] list;
      logic [4:0] single;
      logic [31:0] divcnt;
      logic [31:0] scancnt;
      logic [2:0] entry;
      logic writing;
      logic ovr;
      logic done;
      logic sv_valid;
      logic [23:0] sv_data;
      logic sv_pend;
      logic [aw-1:0] wp;
      logic [aw-1:0] rp;
      logic [aw:0] cnt;
      logic [2:0] trig_sync;
      logic sv_conv;
      logic [31:0] rdata;
      logic [7:0] gain;
   } sada_acq_state_type;

   sada_acq_state_type s_q, s_d;
   logic [23:0] mem_q [fifo_depth];
   logic mem_we;
   logic [aw-1:0] mem_wa;
   logic [23:0] mem_wd;
   logic [7:0] dig_s1_q, dig_s2_q;
   logic conv_start, conv_busy, conv_done;
   logic [4*24-1:0] conv_res;
   logic [7:0] conv_dig;

   // entry decode used in several places
   function automatic logic [2:0] entry_index(input logic [24:0] list, input logic [2:0] n);
      entry_index = list[n*sada_pkg::entry_w +: 3];
   endfunction : entry_index

   function automatic logic [23:0] lane_word(input logic [2:0] idx, input logic [4*24-1:0] res,
                                             input logic [7:0] dig);
      if (idx == sada_pkg::dig_index)
         lane_word = {16'h0000, dig};
      else
         lane_word = res[idx[1:0]*24 +: 24];
   endfunction : lane_word

   sada_conv #(
      .conv_cycles(conv_cycles)
   ) u_conv (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .start_in(conv_start),
      .raw_in(raw_in),
      .over_in(over_in),
      .under_in(under_in),
      .dig_in(dig_s2_q),
      .busy_out(conv_busy),
      .done_out(conv_done),
      .result_out(conv_res),
      .dig_out(conv_dig)
   );

   // pin synchronisers: first stage read only by the second
   always_ff @(posedge clk_in)
   begin
      dig_s1_q <= dig_in;
      dig_s2_q <= dig_s1_q;
   end

   // pacing range 1.173 Hz .. 4800 Hz; stored clamped so software reads back the rate in force
   function automatic logic [31:0] clamp_div(input logic [31:0] v);
      if (v < 32'(sada_pkg::div_min))
         clamp_div = 32'(sada_pkg::div_min);
      else if (v > 32'(sada_pkg::div_max))
         clamp_div = 32'(sada_pkg::div_max);
      else
         clamp_div = v;
   endfunction : clamp_div

   logic [31:0] div_eff;
   logic tick, trig_edge, wr_acc, rd_acc, rd_data, fifo_full, fifo_empty;
   logic [2:0] len;
   assign div_eff = clamp_div(s_q.clkdiv);
   assign len = s_q.ctrl[sada_pkg::ctrl_len_lsb +: 3];
   assign tick = (s_q.st == sada_pkg::st_run) && (s_q.divcnt == 32'h0);
   // edge taken from the second and third stages, so the first stage feeds only the second
   assign trig_edge = s_q.ctrl[sada_pkg::ctrl_fall_bit] ? (s_q.trig_sync[2] && !s_q.trig_sync[1])
                                                       : (!s_q.trig_sync[2] && s_q.trig_sync[1]);
   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign rd_acc = psel_in && penable_in && !pwrite_in;
   assign rd_data = rd_acc && (paddr_in == sada_pkg::data_off);
   assign fifo_full = (s_q.cnt == (aw+1)'(fifo_depth));
   assign fifo_empty = (s_q.cnt == '0);
   assign conv_start = (tick || s_q.sv_pend) && !conv_busy;
   assign mem_we = s_q.writing;
   assign mem_wa = s_q.wp;
   assign mem_wd = lane_word(entry_index(s_q.list, s_q.entry), conv_res, conv_dig);

   always_comb
   begin
      logic pop, push;
      logic [31:0] cmd;
      pop = 1'b0;
      push = 1'b0;
      cmd = '0;
      s_d = s_q;
      s_d.trig_sync = {s_q.trig_sync[1:0], ext_trig_in};
      if (wr_acc && paddr_in == sada_pkg::cmd_off)
         cmd = pwdata_in;
      // register writes
      if (wr_acc)
      begin
         case (paddr_in)
            sada_pkg::ctrl_off: s_d.ctrl = pwdata_in;
            sada_pkg::clkdiv_off: s_d.clkdiv = clamp_div(pwdata_in);
            sada_pkg::scans_off: s_d.scans = pwdata_in;
            sada_pkg::list_off: s_d.list = pwdata_in[24:0];
            sada_pkg::single_off: s_d.single = pwdata_in[4:0];
            default: ;
         endcase
      end
      // sample pacing divider
      if (s_q.st == sada_pkg::st_run)
         s_d.divcnt = (s_q.divcnt == 32'h0) ? div_eff - 32'h1 : s_q.divcnt - 32'h1;
      // overrun: set beats clear
      if (cmd[sada_pkg::cmd_clr_ovr_bit])
         s_d.ovr = 1'b0;
      if (tick && conv_busy)
         s_d.ovr = 1'b1;
      // single value: no clock, trigger or buffer involved
      if (cmd[sada_pkg::cmd_single_bit])
      begin
         s_d.sv_pend = 1'b1;
         s_d.sv_valid = 1'b0;
      end
      // the converter's current owner decides where its result goes: an aborted scan never posts a single
      if (conv_done)
         s_d.sv_conv = 1'b0;
      // a single request yields to a sample pulse in the same cycle so no scan is lost
      if (s_q.sv_pend && !conv_busy && !tick)
      begin
         s_d.sv_pend = 1'b0;
         s_d.sv_conv = 1'b1;
      end
      if (conv_done && s_q.sv_conv)
      begin
         s_d.sv_valid = 1'b1;
         s_d.sv_data = lane_word(s_q.single[2:0], conv_res, conv_dig);
      end
      // scan writer: one word per list entry in list order
      if (conv_done && !s_q.sv_conv && (s_q.st == sada_pkg::st_run || s_q.st == sada_pkg::st_drain))
      begin
         s_d.writing = 1'b1;
         s_d.entry = 3'h0;
      end
      if (s_q.writing)
      begin
         push = 1'b1;
         if (s_q.entry == len - 3'h1 || s_q.entry == 3'(sada_pkg::max_entries - 1))
         begin
            s_d.writing = 1'b0;
            s_d.scancnt = s_q.scancnt + 32'h1;
            if (s_q.st == sada_pkg::st_drain)
               s_d.st = sada_pkg::st_idle;
            else if (!s_q.ctrl[sada_pkg::ctrl_wrap_bit] && s_q.scancnt + 32'h1 >= s_q.scans)
            begin
               s_d.st = sada_pkg::st_idle;
               s_d.done = 1'b1;
            end
         end
         else
            s_d.entry = s_q.entry + 3'h1;
      end
      // fifo: when full, oldest word is dropped so newest scans win
      // limitation: a no-wrap run loses its oldest words too if the host reads too slowly
      pop = rd_data && !fifo_empty;
      if (push && fifo_full && !pop)
         s_d.rp = s_q.rp + 1'b1;
      else if (pop)
         s_d.rp = s_q.rp + 1'b1;
      if (push)
         s_d.wp = s_q.wp + 1'b1;
      if (push && !pop && !fifo_full)
         s_d.cnt = s_q.cnt + 1'b1;
      else if (pop && !push)
         s_d.cnt = s_q.cnt - 1'b1;
      // sequencing
      case (s_q.st)
         sada_pkg::st_idle:
         begin
            if (cmd[sada_pkg::cmd_start_bit] && len != 3'h0)
            begin
               s_d.scancnt = '0;
               s_d.done = 1'b0;
               s_d.divcnt = '0;
               s_d.st = s_q.ctrl[sada_pkg::ctrl_ext_bit] ? sada_pkg::st_armed : sada_pkg::st_run;
            end
         end
         sada_pkg::st_armed:
         begin
            if (trig_edge)
               s_d.st = sada_pkg::st_run;
         end
         sada_pkg::st_run:
         begin
            if (cmd[sada_pkg::cmd_ostop_bit])
               s_d.st = ((conv_busy && !s_q.sv_conv) || s_q.writing) ? sada_pkg::st_drain : sada_pkg::st_idle;
         end
         sada_pkg::st_drain: ;
         default: s_d.st = sada_pkg::st_idle;
      endcase
      if (cmd[sada_pkg::cmd_astop_bit] && s_q.st != sada_pkg::st_idle)
      begin
         // abrupt stop: drop the partial scan and the buffered words
         s_d.st = sada_pkg::st_idle;
         s_d.writing = 1'b0;
         s_d.rp = s_q.wp;
         s_d.wp = s_q.wp;
         s_d.cnt = '0;
      end
      // front-end gain: per-lane from list, or single request
      for (int i = 0; i < sada_pkg::max_entries; i++)
      begin
         if (entry_index(s_q.list, 3'(i)) < sada_pkg::dig_index && 3'(i) < len)
            s_d.gain[entry_index(s_q.list, 3'(i))*2 +: 2] = s_q.list[i*sada_pkg::entry_w + 3 +: 2];
      end
      if (s_q.sv_pend && s_q.single[2:0] < sada_pkg::dig_index)
         s_d.gain[s_q.single[1:0]*2 +: 2] = s_q.single[4:3];
      // read data
      s_d.rdata = '0;
      if (psel_in && !penable_in && !pwrite_in)
      begin
         case (paddr_in)
            sada_pkg::ctrl_off: s_d.rdata = s_q.ctrl;
            sada_pkg::clkdiv_off: s_d.rdata = s_q.clkdiv;
            sada_pkg::scans_off: s_d.rdata = s_q.scancnt;
            sada_pkg::list_off: s_d.rdata = {7'h00, s_q.list};
            sada_pkg::single_off: s_d.rdata = {8'h00, s_q.sv_data};
            sada_pkg::status_off:
            begin
               s_d.rdata[sada_pkg::st_run_bit] = s_q.st != sada_pkg::st_idle;
               s_d.rdata[sada_pkg::st_ovr_bit] = s_q.ovr;
               s_d.rdata[sada_pkg::st_empty_bit] = fifo_empty;
               s_d.rdata[sada_pkg::st_full_bit] = fifo_full;
               s_d.rdata[sada_pkg::st_done_bit] = s_q.done;
               s_d.rdata[sada_pkg::st_sv_bit] = s_q.sv_valid;
            end
            sada_pkg::data_off:
            begin
               // an empty fifo reads zero rather than a stale word
               if (!fifo_empty)
                  s_d.rdata = {8'h00, mem_q[s_q.rp]};
            end
            default: s_d.rdata = '0;
         endcase
      end
      if (psel_in && penable_in)
         s_d.rdata = s_q.rdata;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         s_q <= '0;
         s_q.clkdiv <= sada_pkg::clkdiv_rst;
         s_q.st <= sada_pkg::st_idle;
         // trigger pin idles high on its pull-up; starting the stages high avoids a false rising edge
         s_q.trig_sync <= '1;
      end
      else
         s_q <= s_d;
   end

   always_ff @(posedge clk_in)
   begin
      if (mem_we)
         mem_q[mem_wa] <= mem_wd;
   end

   assign pready_out = psel_in && penable_in;
   assign pslverr_out = psel_in && penable_in && (paddr_in[1:0] != 2'b00 || paddr_in > sada_pkg::cmd_off);
   assign prdata_out = s_q.rdata;
   assign gain_out = s_q.gain;
endmodule : sada_acq
`default_nettype wire

// ===== design/sada_pkg.sv
// package: register map, field positions, timing and state encodings for the acquisition controller
`default_nettype none
package sada_pkg;
   // register byte offsets (apb, one aligned word each)
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] clkdiv_off = 8'h04;
   localparam logic [7:0] scans_off = 8'h08;
   localparam logic [7:0] list_off = 8'h0c;
   localparam logic [7:0] single_off = 8'h10;
   localparam logic [7:0] status_off = 8'h14;
   localparam logic [7:0] data_off = 8'h18;
   localparam logic [7:0] cmd_off = 8'h1c;
   // ctrl fields
   localparam int ctrl_ext_bit = 0;
   localparam int ctrl_fall_bit = 1;
   localparam int ctrl_wrap_bit = 2;
   localparam int ctrl_len_lsb = 4;
   // cmd fields (write-only pulses)
   localparam int cmd_start_bit = 0;
   localparam int cmd_ostop_bit = 1;
   localparam int cmd_astop_bit = 2;
   localparam int cmd_clr_ovr_bit = 3;
   localparam int cmd_single_bit = 4;
   // status fields
   localparam int st_run_bit = 0;
   localparam int st_ovr_bit = 1;
   localparam int st_empty_bit = 2;
   localparam int st_full_bit = 3;
   localparam int st_done_bit = 4;
   localparam int st_sv_bit = 5;
   // list entry: 3-bit index + 2-bit gain code, 5 entries of 5 bits
   localparam int entry_w = 5;
   localparam int max_entries = 5;
   localparam logic [2:0] dig_index = 3'h4;
   // gain codes 0..3 -> 1, 8, 16, 32
   localparam int sample_w = 24;
   localparam logic [23:0] code_over = 24'hffffff;
   localparam logic [23:0] code_under = 24'h000000;
   // clock: 200 MHz; sample rate 1.173 Hz .. 4800 Hz
   localparam int clk_hz = 200000000;
   localparam int rate_max_hz = 4800;
   localparam int div_min = clk_hz / rate_max_hz;
   localparam int div_max = 170502984;
   localparam logic [31:0] clkdiv_rst = 32'd200000;
   localparam int fifo_depth = 8192;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_armed = 2'b01,
      st_run = 2'b10,
      st_drain = 2'b11
   } sada_state_type;
endpackage : sada_pkg
`default_nettype wire

// ===== design/sada_conv.sv
// module: simultaneous converter front for the analog lanes and the digital port
`default_nettype none
module sada_conv #(
   parameter int conv_cycles = 64
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // start request
   input wire logic start_in,
   input wire logic [4*24-1:0] raw_in,
   input wire logic [3:0] over_in,
   input wire logic [3:0] under_in,
   input wire logic [7:0] dig_in,
   // results
   output logic busy_out,
   output logic done_out,
   output logic [4*24-1:0] result_out,
   output logic [7:0] dig_out
);
   initial if (conv_cycles < 1) $error("conv_cycles must be positive");
   typedef struct packed {
      logic [15:0] cnt;
      logic busy;
      logic done;
      logic [4*24-1:0] res;
      logic [7:0] dig;
   } sada_conv_state_type;
   sada_conv_state_type s_q, s_d;
   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (start_in && !s_q.busy)
      begin
         s_d.busy = 1'b1;
         s_d.cnt = 16'(conv_cycles - 1);
         s_d.dig = dig_in;
         for (int i = 0; i < 4; i++)
         begin
            // clamps to full scale in offset binary
            if (over_in[i])
               s_d.res[i*24 +: 24] = sada_pkg::code_over;
            else if (under_in[i])
               s_d.res[i*24 +: 24] = sada_pkg::code_under;
            else
               s_d.res[i*24 +: 24] = raw_in[i*24 +: 24];
         end
      end
      else if (s_q.busy)
      begin
         if (s_q.cnt == 16'h0000)
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
         else
            s_d.cnt = s_q.cnt - 16'h0001;
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign busy_out = s_q.busy;
   assign done_out = s_q.done;
   assign result_out = s_q.res;
   assign dig_out = s_q.dig;
endmodule : sada_conv
`default_nettype wire

// ===== tb/sada_acq_checker.sv
// checker: apb and status relations of the acquisition controller
`default_nettype none
module sada_acq_checker #(
   parameter int fifo_depth = 8,
   parameter int conv_cycles = 4
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] div_q;
   logic [31:0] div_d;
   logic abort_q;
   logic acc;
   logic bad;
   assign acc = psel_in && penable_in;
   assign bad = (paddr_in > 8'h1c) || (paddr_in[1:0] != 2'b00);
   // the clamp is rebuilt here so a one-off bound in the design shows on readback
   assign div_d = (pwdata_in < 32'(sada_pkg::div_min)) ? 32'(sada_pkg::div_min) :
      (pwdata_in > 32'(sada_pkg::div_max)) ? 32'(sada_pkg::div_max) : pwdata_in;
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         div_q <= sada_pkg::clkdiv_rst;
         abort_q <= 1'b0;
      end
      else if (acc && pwrite_in && !bad)
      begin
         if (paddr_in == sada_pkg::clkdiv_off)
            div_q <= div_d;
         if (paddr_in == sada_pkg::cmd_off && pwdata_in[sada_pkg::cmd_astop_bit])
            abort_q <= 1'b1;
         else if (paddr_in == sada_pkg::cmd_off && pwdata_in[sada_pkg::cmd_start_bit])
            abort_q <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   sequence access_s;
      psel_in && penable_in;
   endsequence
   sequence rd_s(logic [7:0] a);
      psel_in && penable_in && !pwrite_in && paddr_in == a;
   endsequence
   ready_now_a: assert property (access_s |-> pready_out)
      else $error("pready low in access phase");
   bad_addr_a: assert property (acc && bad |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
      else $error("bad address not refused");
   good_addr_a: assert property (acc && !bad |-> !pslverr_out)
      else $error("good address refused");
   div_clamp_a: assert property (rd_s(sada_pkg::clkdiv_off) |-> prdata_out == div_q)
      else $error("pacing divider readback wrong");
   data_width_a: assert property (rd_s(sada_pkg::data_off) |-> prdata_out[31:24] == 8'h00)
      else $error("fifo word wider than sample");
   single_width_a: assert property (rd_s(sada_pkg::single_off) |-> prdata_out[31:24] == 8'h00)
      else $error("single result wider than sample");
   fifo_flags_a: assert property (rd_s(sada_pkg::status_off) |->
      !(prdata_out[sada_pkg::st_full_bit] && prdata_out[sada_pkg::st_empty_bit]))
      else $error("fifo full and empty together");
   abort_clean_a: assert property (rd_s(sada_pkg::status_off) ##0 abort_q |->
      !prdata_out[sada_pkg::st_run_bit] && prdata_out[sada_pkg::st_empty_bit])
      else $error("data or run left after abrupt stop");
endmodule : sada_acq_checker
bind sada_acq sada_acq_checker #(.fifo_depth(fifo_depth), .conv_cycles(conv_cycles)) i_chk (
   .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire

// ===== tb/sada_far.sv
// far side model: converter lanes, range flags, digital switches, trigger pin
`default_nettype none
module sada_far (
   // clock and bench commands
   input wire logic clk_in,
   input wire logic fire_in,
   input wire logic [3:0] over_sel_in,
   input wire logic [3:0] under_sel_in,
   input wire logic [7:0] switch_in,
   // toward the block
   output logic [4*24-1:0] raw_out,
   output logic [3:0] over_out,
   output logic [3:0] under_out,
   output logic [7:0] dig_out,
   output logic ext_trig_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] low_q = 3'd0;
   // lane i sits i codes above midscale, code 800000h being 0 V
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         raw_out[i*24+:24] = 24'h800000 + 24'(i);
      end
   end
   assign over_out = over_sel_in;
   assign under_out = under_sel_in;
   assign dig_out = switch_in;
   // pulled up between pulses; a request pulls it low for six cycles
   always_ff @(posedge clk_in)
   begin
      low_q <= fire_in ? 3'd6 : ((low_q != 3'd0) ? low_q - 3'd1 : 3'd0);
   end
   assign ext_trig_out = (low_q == 3'd0);
endmodule : sada_far
`default_nettype wire

// ===== tb/tb.sv
// testbench: apb scenarios for the acquisition controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int conv = 4;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic fire = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] over_sel = 4'h0;
   logic [3:0] under_sel = 4'h0;
   logic [7:0] sw = 8'ha5;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [95:0] raw;
   logic [3:0] over;
   logic [3:0] under;
   logic [7:0] gain;
   logic [7:0] dig;
   logic trig;
   int n_mismatch = 0;
   int checked = 0;
   always #2.5 clk_in = ~clk_in;
   sada_acq #(.fifo_depth(8), .conv_cycles(conv)) i_dut (
      .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .raw_in(raw), .over_in(over),
      .under_in(under), .gain_out(gain), .ext_trig_in(trig), .dig_in(dig));
   sada_far i_far (
      .clk_in(clk_in), .fire_in(fire), .over_sel_in(over_sel), .under_sel_in(under_sel),
      .switch_in(sw), .raw_out(raw), .over_out(over), .under_out(under), .dig_out(dig),
      .ext_trig_out(trig));
   task tally_and_finish;
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // request held until pready is sampled high, then released
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1 && n < 64)
      begin
         n++;
         @(posedge clk_in);
      end
      if (n == 64)
         n_mismatch++;
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] r);
      apb(1'b0, a, 32'h0, r);
   endtask : rd
   task poll(input int b, input logic v, output logic [31:0] r);
      int n;
      n = 0;
      rd(sada_pkg::status_off, r);
      while (r[b] !== v && n < 20000)
      begin
         n++;
         rd(sada_pkg::status_off, r);
      end
   endtask : poll
   task pulse;
      @(posedge clk_in);
      fire <= 1'b1;
      @(posedge clk_in);
      fire <= 1'b0;
   endtask : pulse
   task t_regs;
      logic [31:0] r;
      rd(sada_pkg::clkdiv_off, r);
      chk("divider reset", r, sada_pkg::clkdiv_rst);
      rd(sada_pkg::status_off, r);
      chk("status reset", r & 32'h7, 32'h4);
      wr(sada_pkg::clkdiv_off, 32'h1);
      rd(sada_pkg::clkdiv_off, r);
      chk("divider low clamp", r, 32'(sada_pkg::div_min));
      wr(sada_pkg::clkdiv_off, 32'hffffffff);
      rd(sada_pkg::clkdiv_off, r);
      chk("divider high clamp", r, 32'(sada_pkg::div_max));
      rd(8'h20, r);
      chk("unmapped read", r, 32'h0);
   endtask : t_regs
   task t_single;
      logic [31:0] r;
      logic [31:0] e;
      over_sel <= 4'b0010;
      under_sel <= 4'b0100;
      for (int i = 0; i < 5; i++)
      begin
         e = (i == 4) ? {24'h0, sw} : (i == 1) ? 32'hffffff : (i == 2) ? 32'h0 : 32'h800000 + 32'(i);
         wr(sada_pkg::single_off, 32'((i % 4) * 8 + i));
         wr(sada_pkg::cmd_off, 32'h10);
         repeat (conv + 2) @(posedge clk_in);
         poll(sada_pkg::st_sv_bit, 1'b1, r);
         rd(sada_pkg::single_off, r);
         chk("single result", r, e);
         if (i < 4)
            chk("lane gain", 32'(gain[2*i+:2]), 32'(i));
      end
      over_sel <= 4'h0;
      under_sel <= 4'h0;
   endtask : t_single
   task t_abort;
      logic [31:0] r;
      wr(sada_pkg::ctrl_off, 32'h10);
      wr(sada_pkg::list_off, 32'h3);
      // a single conversion still busy when the first sample pulse lands forces an overrun
      wr(sada_pkg::cmd_off, 32'h10);
      wr(sada_pkg::cmd_off, 32'h1);
      repeat (conv * 4) @(posedge clk_in);
      wr(sada_pkg::cmd_off, 32'h4);
      rd(sada_pkg::status_off, r);
      chk("abrupt stop state", r & 32'h5, 32'h4);
      chk("overrun flagged", r[sada_pkg::st_ovr_bit], 1'b1);
      wr(sada_pkg::cmd_off, 32'h8);
      rd(sada_pkg::status_off, r);
      chk("overrun cleared", r[sada_pkg::st_ovr_bit], 1'b0);
   endtask : t_abort
   task t_cont;
      logic [31:0] r;
      logic [31:0] e [3];
      e = '{32'h800002, 32'h0000a5, 32'h800000};
      wr(sada_pkg::ctrl_off, 32'h30);
      wr(sada_pkg::list_off, 32'h608a);
      wr(sada_pkg::clkdiv_off, 32'h1);
      wr(sada_pkg::scans_off, 32'h1);
      wr(sada_pkg::cmd_off, 32'h1);
      rd(sada_pkg::status_off, r);
      chk("run after start", r[sada_pkg::st_run_bit], 1'b1);
      poll(sada_pkg::st_done_bit, 1'b1, r);
      chk("scan count done", r[sada_pkg::st_done_bit], 1'b1);
      rd(sada_pkg::scans_off, r);
      chk("scans acquired", r, 32'h1);
      for (int k = 0; k < 3; k++)
      begin
         rd(sada_pkg::data_off, r);
         chk("scan word", r, e[k]);
      end
      rd(sada_pkg::status_off, r);
      chk("ended and drained", r & 32'h5, 32'h4);
   endtask : t_cont
   task t_ext;
      logic [31:0] r;
      wr(sada_pkg::ctrl_off, 32'h13);
      wr(sada_pkg::list_off, 32'h11);
      wr(sada_pkg::scans_off, 32'h4);
      wr(sada_pkg::cmd_off, 32'h1);
      repeat (100) @(posedge clk_in);
      rd(sada_pkg::status_off, r);
      chk("no data before edge", r[sada_pkg::st_empty_bit], 1'b1);
      pulse();
      poll(sada_pkg::st_empty_bit, 1'b0, r);
      chk("data after edge", r[sada_pkg::st_empty_bit], 1'b0);
      wr(sada_pkg::cmd_off, 32'h2);
      poll(sada_pkg::st_run_bit, 1'b0, r);
      chk("halted by stop", r[sada_pkg::st_run_bit], 1'b0);
      pulse();
      repeat (100) @(posedge clk_in);
      rd(sada_pkg::status_off, r);
      chk("later edge ignored", r[sada_pkg::st_run_bit], 1'b0);
      rd(sada_pkg::data_off, r);
      chk("stopped data kept", r, 32'h800001);
      wr(sada_pkg::ctrl_off, 32'h11);
      wr(sada_pkg::cmd_off, 32'h1);
      pulse();
      poll(sada_pkg::st_empty_bit, 1'b0, r);
      rd(sada_pkg::data_off, r);
      chk("rising edge data", r, 32'h800001);
   endtask : t_ext
   initial
   begin
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      t_regs();
      t_single();
      t_abort();
      t_cont();
      t_ext();
      tally_and_finish();
   end
   // the scenarios need under two thousand cycles; ten times that means a hang
   initial
   begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
